// ===== rtl/eifm_pkg.sv
`default_nettype none

package eifm_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int DISC_TOL_NS   = 2000;
	localparam int DISC_TOL_CYC  = (DISC_TOL_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int MIN_PHASE_NS  = 200;
	localparam int MIN_PHASE_CYC = (MIN_PHASE_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int FREQ_WIN_NS   = 1000000;
	localparam int FREQ_WIN_CYC  = FREQ_WIN_NS / CLK_PERIOD_NS;
	localparam int FREQ_TOL_EDGES = 2;
	localparam int STUCK_EDGES   = 16;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int CNT_W  = 16;
	localparam int WIN_W  = 20;
	localparam int EDGE_W = 8;
	localparam int STK_W  = 8;
	localparam int NUM_IN = 4;

	// ----------------------------------------------------------------
	// Fault flag positions
	// ----------------------------------------------------------------
	localparam int FL_DIR1    = 0;
	localparam int FL_DIR2    = 1;
	localparam int FL_A1N_IN2 = 2;
	localparam int FL_A1N_IN3 = 3;
	localparam int FL_SEN2_A  = 4;
	localparam int FL_B       = 5;
	localparam int FL_FREQ1   = 6;
	localparam int FL_FREQ2   = 7;
	localparam int FL_PHASE1  = 8;
	localparam int FL_PHASE2  = 9;
	localparam int NUM_FLAGS  = 10;

	// Stuck-at cause byte: bit 2*i high, bit 2*i+1 low for input i
	localparam int STUCK_HI_OFS = 0;
	localparam int STUCK_LO_OFS = 1;

	// ----------------------------------------------------------------
	// Error codes, index = flag position
	// ----------------------------------------------------------------
	localparam logic [NUM_FLAGS-1:0][31:0] FLAG_CODE = {
		32'h23100222, 32'h23100221, 32'h23100242, 32'h23100241,
		32'h23100238, 32'h23100234, 32'h23100232, 32'h23100231,
		32'h23100205, 32'h23100204};
	localparam logic [23:0] CODE_STUCK_BASE = 24'h231003;
	localparam logic [31:0] CODE_NONE       = 32'h00000000;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [CNT_W-1:0] SINCE_RST = 16'hFFFF;
	localparam logic [3:0]       REL_RST   = 4'h0;

	typedef enum logic [1:0] {
		LAY_AB_ANTI,
		LAY_TWO_A_ANTI,
		LAY_TWO_AB,
		LAY_NONE
	} eifm_layout_e;

endpackage

`default_nettype wire

// ===== rtl/eifm_sync.sv
`timescale 1ns/1ns
`default_nettype none

module eifm_sync
	import eifm_pkg::*;
(
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	// Pin and filtered level
	input  wire logic pin_i,
	output logic      level_o
);

	typedef struct packed {
		logic ff1;
		logic ff2;
		logic ff3;
		logic level;
	} eifm_sync_s;

	eifm_sync_s st_r;
	eifm_sync_s st_nxt;

	always_comb
	begin
		st_nxt     = st_r;
		st_nxt.ff1 = pin_i;
		st_nxt.ff2 = st_r.ff1;
		st_nxt.ff3 = st_r.ff2;
		// Change counts once stages two and three agree
		if (st_r.ff2 == st_r.ff3)
		begin
			st_nxt.level = st_r.ff3;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			st_r <= '0;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	assign level_o = st_r.level;

endmodule // eifm_sync

`default_nettype wire

// ===== rtl/eifm_chan.sv
`timescale 1ns/1ns
`default_nettype none

module eifm_chan
	import eifm_pkg::*;
#(
	parameter logic [EDGE_W-1:0] STUCK_LIMIT = EDGE_W'(STUCK_EDGES)
)
(
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	// Own track and partner activity
	input  wire logic level_i,
	input  wire logic edge_i,
	input  wire logic partner_edge_i,
	// Stuck indications
	output logic      stuck_hi_o,
	output logic      stuck_lo_o
);

	typedef struct packed {
		logic [EDGE_W-1:0] cnt;
	} eifm_chan_s;

	eifm_chan_s st_r;
	eifm_chan_s st_nxt;
	logic       dead;

	// Partner edges seen while this track stays still
	always_comb
	begin
		st_nxt = st_r;
		if (edge_i)
		begin
			st_nxt.cnt = '0;
		end
		else if (partner_edge_i && st_r.cnt != STUCK_LIMIT)
		begin
			st_nxt.cnt = st_r.cnt + EDGE_W'(1);
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			st_r <= '0;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	assign dead       = (st_r.cnt == STUCK_LIMIT);
	assign stuck_hi_o = dead & level_i;
	assign stuck_lo_o = dead & ~level_i;

endmodule // eifm_chan

`default_nettype wire

// ===== rtl/eifm_top.sv
// What this block does
// - Sensor one A equal to its complement on second input: 23100231.
// - Sensor one A equal to its complement on third input: 23100232.
// - Sensor two A against its complement mismatch raises 23100234.
// - B against B/ mismatch raises code 23100238.
// - True and complementary direction differ: 23100204 sensor one, 205 two.
// - A and B edge counts differ: 23100241 sensor one, 242 two.
// - Stuck faults report 231003xx, low byte a cause mask, bits combine.
// - Cause bit 0 first input stuck high, bit 1 stuck low.
// - Cause bit 2 second input stuck high, bit 3 stuck low.
// - Cause bit 4 third input stuck high, bit 5 stuck low.
// - Cause bit 6 fourth input stuck high, bit 7 stuck low.
// - Pulses on one track while partner track is still means stuck.
// - Ground short reads stuck low; push-pull cable break reads stuck.
// - Short to 24 V reads stuck high on that input.
// - A/B phase shift too small: 23100221 sensor one, 222 two.
// - Combined A/B signal losing edges also raises the phase fault.
// - Collective fault output is high while any fault is active.
// - Any fault forces every release output inactive.
`timescale 1ns/1ns
`default_nettype none

module eifm_top
	import eifm_pkg::*;
#(
	parameter int DISC_TOL  = DISC_TOL_CYC,
	parameter int MIN_PHASE = MIN_PHASE_CYC,
	parameter int FREQ_WIN  = FREQ_WIN_CYC,
	parameter int FREQ_TOL  = FREQ_TOL_EDGES
)
(
	// Clock and reset
	input  wire logic                 REF_CLK_I,
	input  wire logic                 RESET_N_I,
	// Sensor pins
	input  wire logic                 FIRST_SENSOR_INPUT_I,
	input  wire logic                 SECOND_SENSOR_INPUT_I,
	input  wire logic                 THIRD_SENSOR_INPUT_I,
	input  wire logic                 FOURTH_SENSOR_INPUT_I,
	// Configuration and control
	input  wire logic [1:0]           CFG_LAYOUT_I,
	input  wire logic                 FAULT_CLR_I,
	input  wire logic [3:0]           RELEASE_REQ_I,
	// Fault reporting
	output logic      [31:0]          ERROR_CODE_O,
	output logic                      FAULT_O,
	output logic      [NUM_FLAGS-1:0] FAULT_FLAGS_O,
	output logic      [STK_W-1:0]     STUCK_CAUSE_O,
	// Release
	output logic      [3:0]           RELEASE_O
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [NUM_IN-1:0]          prev;
		logic [2:0][CNT_W-1:0]      pers;
		logic                       dir_t;
		logic                       dir_c;
		logic [1:0][CNT_W-1:0]      since_a;
		logic [1:0][CNT_W-1:0]      since_b;
		logic [WIN_W-1:0]           win;
		logic [1:0][EDGE_W-1:0]     cnt_a;
		logic [1:0][EDGE_W-1:0]     cnt_b;
		logic [NUM_FLAGS-1:0]       flags;
		logic [STK_W-1:0]           stuck;
		logic [31:0]                code;
		logic                       fault;
		logic [3:0]                 rel;
	} eifm_top_s;

	localparam logic [CNT_W-1:0] TOL_M1   = CNT_W'(DISC_TOL - 1);
	localparam logic [CNT_W-1:0] MINPH    = CNT_W'(MIN_PHASE);
	localparam logic [WIN_W-1:0] WIN_M1   = WIN_W'(FREQ_WIN - 1);
	localparam logic [EDGE_W:0]  FTOL     = (EDGE_W+1)'(FREQ_TOL);
	localparam logic [EDGE_W-1:0] EDGE_MX = '1;

	eifm_top_s         st_r;
	eifm_top_s         st_nxt;
	logic [NUM_IN-1:0] pin;
	logic [NUM_IN-1:0] lvl;
	logic [NUM_IN-1:0] edg;
	logic [NUM_IN-1:0] stk_hi;
	logic [NUM_IN-1:0] stk_lo;
	logic [2:0]        mis;
	logic [NUM_FLAGS-1:0] ev;
	logic [STK_W-1:0]  sev;
	logic [1:0]        sen_en;
	logic              t_a;
	logic              t_b;
	logic              c_a;
	logic              c_b;
	logic              t_ea;
	logic              c_ea;
	logic [EDGE_W:0]   diff;
	eifm_layout_e      lay;

	assign pin = {FOURTH_SENSOR_INPUT_I, THIRD_SENSOR_INPUT_I,
		SECOND_SENSOR_INPUT_I, FIRST_SENSOR_INPUT_I};

	// ----------------------------------------------------------------
	// Input synchronisers and stuck-at monitors
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < NUM_IN; gi++)
		begin : g_in
			eifm_sync eifm_sync_i (
				.clk_i   (REF_CLK_I),
				.rst_n_i (RESET_N_I),
				.pin_i   (pin[gi]),
				.level_o (lvl[gi])
			);
			eifm_chan eifm_chan_i (
				.clk_i          (REF_CLK_I),
				.rst_n_i        (RESET_N_I),
				.level_i        (lvl[gi]),
				.edge_i         (edg[gi]),
				.partner_edge_i (edg[gi ^ 2]),
				.stuck_hi_o     (stk_hi[gi]),
				.stuck_lo_o     (stk_lo[gi])
			);
		end
	endgenerate

	assign edg = lvl ^ st_r.prev;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		st_nxt      = st_r;
		ev          = '0;
		sev         = '0;
		mis         = '0;
		sen_en      = '0;
		diff        = '0;
		lay         = eifm_layout_e'(CFG_LAYOUT_I);
		t_a         = lvl[0];
		t_b         = lvl[2];
		c_a         = lvl[1];
		c_b         = lvl[3];
		t_ea        = edg[0];
		c_ea        = edg[1];
		st_nxt.prev = lvl;

		// Pairing of inputs for each wiring layout
		case (lay)
			LAY_AB_ANTI:
			begin
				mis[0] = (lvl[0] == lvl[1]);
				mis[1] = (lvl[2] == lvl[3]);
				mis[2] = (st_r.dir_t != st_r.dir_c);
				sen_en = 2'b01;
			end
			LAY_TWO_A_ANTI:
			begin
				mis[0] = (lvl[0] == lvl[2]);
				mis[1] = (lvl[1] == lvl[3]);
				mis[2] = (st_r.dir_t != st_r.dir_c);
				t_b    = lvl[1];
				c_a    = lvl[2];
				c_ea   = edg[2];
			end
			LAY_TWO_AB:
			begin
				sen_en = 2'b11;
			end
			default:
			begin
				sen_en = 2'b00;
			end
		endcase

		// Direction latched on each A edge of true and inverted pairs
		if (t_ea)
		begin
			st_nxt.dir_t = t_a ^ t_b;
		end
		if (c_ea)
		begin
			st_nxt.dir_c = c_a ^ c_b;
		end

		// Mismatch must persist for the tolerance before it counts
		for (int k = 0; k < 3; k++)
		begin
			if (!mis[k])
			begin
				st_nxt.pers[k] = '0;
			end
			else if (st_r.pers[k] != TOL_M1)
			begin
				st_nxt.pers[k] = st_r.pers[k] + CNT_W'(1);
			end
		end
		if (mis[0] && st_r.pers[0] == TOL_M1)
		begin
			if (lay == LAY_AB_ANTI)
				ev[FL_A1N_IN2] = 1'b1;
			else
				ev[FL_A1N_IN3] = 1'b1;
		end
		if (mis[1] && st_r.pers[1] == TOL_M1)
		begin
			if (lay == LAY_AB_ANTI)
				ev[FL_B] = 1'b1;
			else
				ev[FL_SEN2_A] = 1'b1;
		end
		if (mis[2] && st_r.pers[2] == TOL_M1)
		begin
			if (lay == LAY_AB_ANTI)
				ev[FL_DIR1] = 1'b1;
			else
				ev[FL_DIR2] = 1'b1;
		end

		// Phase and frequency per A/B sensor: A on input s, B on s+2
		st_nxt.win = (st_r.win == WIN_M1) ? '0 : st_r.win + WIN_W'(1);
		for (int s = 0; s < 2; s++)
		begin
			st_nxt.since_a[s] = edg[s] ? '0 :
				(st_r.since_a[s] == SINCE_RST ? st_r.since_a[s]
				: st_r.since_a[s] + CNT_W'(1));
			st_nxt.since_b[s] = edg[s+2] ? '0 :
				(st_r.since_b[s] == SINCE_RST ? st_r.since_b[s]
				: st_r.since_b[s] + CNT_W'(1));
			if (sen_en[s] && ((edg[s] && edg[s+2])
				|| (edg[s] && st_r.since_b[s] < MINPH)
				|| (edg[s+2] && st_r.since_a[s] < MINPH)))
			begin
				ev[FL_PHASE1 + s] = 1'b1;
			end
			if (edg[s] && st_r.cnt_a[s] != EDGE_MX)
			begin
				st_nxt.cnt_a[s] = st_r.cnt_a[s] + EDGE_W'(1);
			end
			if (edg[s+2] && st_r.cnt_b[s] != EDGE_MX)
			begin
				st_nxt.cnt_b[s] = st_r.cnt_b[s] + EDGE_W'(1);
			end
			if (st_r.win == WIN_M1)
			begin
				diff = (st_r.cnt_a[s] > st_r.cnt_b[s])
					? {1'b0, st_r.cnt_a[s]} - {1'b0, st_r.cnt_b[s]}
					: {1'b0, st_r.cnt_b[s]} - {1'b0, st_r.cnt_a[s]};
				if (sen_en[s] && diff > FTOL)
				begin
					ev[FL_FREQ1 + s] = 1'b1;
				end
				st_nxt.cnt_a[s] = '0;
				st_nxt.cnt_b[s] = '0;
			end
		end

		// Stuck-at cause mask, several bits may stand together
		for (int i = 0; i < NUM_IN; i++)
		begin
			sev[2*i + STUCK_HI_OFS] = stk_hi[i];
			sev[2*i + STUCK_LO_OFS] = stk_lo[i];
		end

		// Sticky faults; a new event wins over a clear in the same cycle
		st_nxt.flags = (FAULT_CLR_I ? '0 : st_r.flags) | ev;
		st_nxt.stuck = (FAULT_CLR_I ? '0 : st_r.stuck) | sev;

		// Reported code: stuck first, then lowest flag position
		st_nxt.code = CODE_NONE;
		for (int f = NUM_FLAGS - 1; f >= 0; f--)
		begin
			if (st_nxt.flags[f])
			begin
				st_nxt.code = FLAG_CODE[f];
			end
		end
		if (st_nxt.stuck != '0)
		begin
			st_nxt.code = {CODE_STUCK_BASE, st_nxt.stuck};
		end

		st_nxt.fault = (st_nxt.flags != '0) || (st_nxt.stuck != '0);
		st_nxt.rel   = RELEASE_REQ_I & {4{~st_nxt.fault}};
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge REF_CLK_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
		begin
			st_r         <= '0;
			st_r.since_a <= {2{SINCE_RST}};
			st_r.since_b <= {2{SINCE_RST}};
			st_r.code    <= CODE_NONE;
			st_r.rel     <= REL_RST;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	assign ERROR_CODE_O  = st_r.code;
	assign FAULT_O       = st_r.fault;
	assign FAULT_FLAGS_O = st_r.flags;
	assign STUCK_CAUSE_O = st_r.stuck;
	assign RELEASE_O     = st_r.rel;

endmodule // eifm_top

`default_nettype wire

// ===== tb/eifm_properties.sv
`timescale 1ns/1ns
`default_nettype none

module eifm_properties
	import eifm_pkg::*;
(
	// Clock, reset and control
	input wire logic                 REF_CLK_I,
	input wire logic                 RESET_N_I,
	input wire logic [1:0]           CFG_LAYOUT_I,
	input wire logic                 FAULT_CLR_I,
	input wire logic [3:0]           RELEASE_REQ_I,
	// Fault reporting
	input wire logic [31:0]          ERROR_CODE_O,
	input wire logic                 FAULT_O,
	input wire logic [NUM_FLAGS-1:0] FAULT_FLAGS_O,
	input wire logic [STK_W-1:0]     STUCK_CAUSE_O,
	input wire logic [3:0]           RELEASE_O
);
	default clocking cb @(posedge REF_CLK_I);
	endclocking
	default disable iff (!RESET_N_I);

	// Lowest set flag selects the reported code
	function automatic logic [31:0] low_code(logic [NUM_FLAGS-1:0] f);
		low_code = CODE_NONE;
		for (int i = NUM_FLAGS - 1; i >= 0; i--)
			if (f[i])
				low_code = FLAG_CODE[i];
	endfunction

	a_release_gate: assert property (
		$past(RESET_N_I) |->
		RELEASE_O == ($past(RELEASE_REQ_I) & ~{4{FAULT_O}}))
		else $error("release active during fault");
	a_fault_any: assert property (
		FAULT_O == (|FAULT_FLAGS_O || |STUCK_CAUSE_O))
		else $error("collective fault wrong");
	a_flag_code: assert property (
		STUCK_CAUSE_O == 8'h00 |-> ERROR_CODE_O == low_code(FAULT_FLAGS_O))
		else $error("flag code wrong");
	a_stuck_code: assert property (
		STUCK_CAUSE_O != 8'h00 |->
		ERROR_CODE_O == {CODE_STUCK_BASE, STUCK_CAUSE_O})
		else $error("stuck code wrong");
	a_flags_hold: assert property (
		$past(RESET_N_I) && !$past(FAULT_CLR_I) |->
		(FAULT_FLAGS_O & $past(FAULT_FLAGS_O)) == $past(FAULT_FLAGS_O))
		else $error("flag dropped without clear");
	a_cause_hold: assert property (
		$past(RESET_N_I) && !$past(FAULT_CLR_I) |->
		(STUCK_CAUSE_O & $past(STUCK_CAUSE_O)) == $past(STUCK_CAUSE_O))
		else $error("cause dropped without clear");
	a_reset_quiet: assert property (
		$rose(RESET_N_I) |-> !FAULT_O && RELEASE_O == 4'h0)
		else $error("outputs active after reset");
	a_in2_layout: assert property (
		$rose(FAULT_FLAGS_O[FL_A1N_IN2]) |-> $past(CFG_LAYOUT_I) == 2'h0)
		else $error("second input flag in wrong layout");
	a_in3_layout: assert property (
		$rose(FAULT_FLAGS_O[FL_A1N_IN3]) |-> $past(CFG_LAYOUT_I) == 2'h1)
		else $error("third input flag in wrong layout");
	a_two_layout: assert property (
		$rose(FAULT_FLAGS_O[FL_SEN2_A]) |-> $past(CFG_LAYOUT_I) == 2'h1)
		else $error("sensor two flag in wrong layout");
	a_b_layout: assert property (
		$rose(FAULT_FLAGS_O[FL_B]) |-> $past(CFG_LAYOUT_I) == 2'h0)
		else $error("track b flag in wrong layout");

	c_phase: cover property (FAULT_FLAGS_O[FL_PHASE1]);
	c_combo: cover property (STUCK_CAUSE_O == 8'h09);
	c_cleared: cover property ($fell(FAULT_O));
endmodule // eifm_properties

bind eifm_top eifm_properties eifm_properties_i (
	.REF_CLK_I, .RESET_N_I, .CFG_LAYOUT_I, .FAULT_CLR_I, .RELEASE_REQ_I,
	.ERROR_CODE_O, .FAULT_O, .FAULT_FLAGS_O, .STUCK_CAUSE_O, .RELEASE_O
);

`default_nettype wire

// ===== tb/eifm_enc_model.sv
`timescale 1ns/1ns
`default_nettype none

module eifm_enc_model
(
	// Clock and mode
	input  wire logic       clk_i,
	input  wire logic       run_i,
	input  wire logic [1:0] layout_i,
	input  wire logic       b_bad_i,
	input  wire logic       in_phase_i,
	input  wire logic       b_slow_i,
	// Static levels and pin faults
	input  wire logic [3:0] level_i,
	input  wire logic [3:0] force_hi_i,
	input  wire logic [3:0] force_lo_i,
	// Sensor pins
	output logic      [3:0] pin_o
);
	logic [5:0] cnt_r = 6'h00;
	logic       a;
	logic       b;
	logic       bc;
	logic [3:0] raw;

	always_ff @(posedge clk_i)
		cnt_r <= cnt_r + 6'h01;

	// Tracks a quarter period apart; B may be slow, in phase or not inverted
	always_comb
	begin
		a = cnt_r[3];
		b = in_phase_i ? a : (b_slow_i ? cnt_r[5] : cnt_r[3] ^ cnt_r[2]);
		bc = b_bad_i ? b : ~b;
		case (layout_i)
			2'h1: raw = {bc, ~a, b, a};
			2'h2: raw = {b, b, a, a};
			default: raw = {bc, b, ~a, a};
		endcase
		pin_o = run_i ? (raw | force_hi_i) & ~force_lo_i : level_i;
	end
endmodule // eifm_enc_model

`default_nettype wire

// ===== tb/test_encoder_input_fault_monitor.sv
`timescale 1ns/1ns
`default_nettype none

`define CHK(g, e) \
	begin \
		checked++; \
		if ((g) !== (e)) \
		begin \
			n_mismatch++; \
			$display("unexpected at %0t: got %h want %h", $time, g, e); \
		end \
	end

module test_encoder_input_fault_monitor;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [1:0]  lay = 2'h3;
	logic        clr = 1'b0;
	logic [3:0]  req = 4'hA;
	logic        mrun = 1'b0;
	logic        bbad = 1'b0;
	logic        inph = 1'b0;
	logic        bslow = 1'b0;
	logic [3:0]  fhi = 4'h0;
	logic [3:0]  flo = 4'h0;
	logic [3:0]  lvl = 4'h0;
	logic [3:0]  pin;
	logic [31:0] code;
	logic        fault;
	logic [9:0]  flags;
	logic [7:0]  cause;
	logic [3:0]  rel;
	int          n_mismatch = 0;
	int          checked = 0;

	always #5 clk = ~clk;

	eifm_top #(.DISC_TOL(4), .MIN_PHASE(3), .FREQ_WIN(64), .FREQ_TOL(2))
	eifm_top_i (
		.REF_CLK_I(clk), .RESET_N_I(rst_n),
		.FIRST_SENSOR_INPUT_I(pin[0]), .SECOND_SENSOR_INPUT_I(pin[1]),
		.THIRD_SENSOR_INPUT_I(pin[2]), .FOURTH_SENSOR_INPUT_I(pin[3]),
		.CFG_LAYOUT_I(lay), .FAULT_CLR_I(clr), .RELEASE_REQ_I(req),
		.ERROR_CODE_O(code), .FAULT_O(fault), .FAULT_FLAGS_O(flags),
		.STUCK_CAUSE_O(cause), .RELEASE_O(rel)
	);

	eifm_enc_model eifm_enc_model_i (
		.clk_i(clk), .run_i(mrun), .layout_i(lay), .b_bad_i(bbad),
		.in_phase_i(inph), .b_slow_i(bslow), .level_i(lvl),
		.force_hi_i(fhi), .force_lo_i(flo), .pin_o(pin)
	);

	task automatic final_report();
		if (n_mismatch == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic restart(input logic [1:0] l);
		rst_n = 1'b0;
		lay = l;
		settle(3);
		rst_n = 1'b1;
	endtask

	task automatic pulse_clear();
		clr = 1'b1;
		settle(1);
		clr = 1'b0;
	endtask

	task automatic wait_fault(input int bound);
		int k;
		for (k = 0; k < bound && fault !== 1'b1; k++)
			settle(1);
		if (k == bound)
		begin
			`CHK(fault, 1'b1)
			final_report();
		end
	endtask

	// Start-up transients are cleared before the fault is judged
	task automatic dyn(input logic [1:0] l, input logic [9:0] m);
		restart(l);
		settle(40);
		pulse_clear();
		wait_fault(300);
		settle(150);
		`CHK(flags & m, m)
		`CHK({fault, rel}, 5'h10)
	endtask

	task automatic t_reset();
		restart(2'h3);
		settle(5);
		`CHK({fault, code}, 33'h0)
		`CHK(rel, req)
	endtask

	// Static pin patterns chosen so no direction capture can interfere
	task automatic t_static();
		logic [1:0]  ls [4] = '{2'h0, 2'h0, 2'h1, 2'h1};
		logic [3:0]  bad [4] = '{4'h4, 4'hD, 4'h2, 4'hE};
		logic [3:0]  good [4] = '{4'h5, 4'h5, 4'h3, 4'h6};
		logic [9:0]  fl [4] = '{10'h004, 10'h020, 10'h008, 10'h010};
		logic [31:0] cd [4] = '{32'h23100231, 32'h23100238,
			32'h23100232, 32'h23100234};
		for (int i = 0; i < 4; i++)
		begin
			lvl = bad[i];
			restart(ls[i]);
			settle(30);
			pulse_clear();
			settle(12);
			`CHK(flags, fl[i])
			`CHK(code, cd[i])
			`CHK(rel, 4'h0)
			lvl = good[i];
			settle(10);
			pulse_clear();
			settle(2);
			`CHK({fault, rel}, {1'b0, req})
		end
	endtask

	// Complementary release pattern so every release bit is gated once
	task automatic t_clean();
		mrun = 1'b1;
		req = 4'h5;
		for (int l = 0; l < 3; l++)
		begin
			restart(2'(l));
			settle(30);
			pulse_clear();
			settle(300);
			`CHK({fault, flags, rel}, {11'h000, req})
		end
	endtask

	task automatic t_dir();
		bbad = 1'b1;
		dyn(2'h0, 10'h001);
		dyn(2'h1, 10'h002);
		bbad = 1'b0;
	endtask

	task automatic t_phase();
		inph = 1'b1;
		dyn(2'h0, 10'h100);
		`CHK(code, 32'h23100221)
		dyn(2'h2, 10'h300);
		inph = 1'b0;
	endtask

	task automatic t_freq();
		bslow = 1'b1;
		dyn(2'h2, 10'h0C0);
		bslow = 1'b0;
	endtask

	// Cause bit 2i is input i stuck high, 2i+1 stuck low; last case combines
	task automatic t_stuck();
		logic [7:0] e;
		for (int b = 0; b < 9; b++)
		begin
			e = (b == 8) ? 8'h09 : 8'h01 << b;
			fhi = {e[6], e[4], e[2], e[0]};
			flo = {e[7], e[5], e[3], e[1]};
			restart(2'h3);
			wait_fault(300);
			settle(3);
			`CHK(cause, e)
			`CHK(code, {24'h231003, e})
		end
		fhi = 4'h0;
		flo = 4'h0;
	endtask

	initial
	begin
		settle(1);
		t_reset();
		t_static();
		t_clean();
		t_dir();
		t_phase();
		t_freq();
		t_stuck();
		final_report();
	end
endmodule // test_encoder_input_fault_monitor

`default_nettype wire
